// file: core/ctw_core_timer.sv
/*
  Core timer with periodic tick and software watchdog, reached over
  AXI4-Lite. SYS_CLK is the oscillator clock. Option inputs are static
  settings on SYS_CLK; STOP_REQ is a one-cycle pulse from the processor.
*/
// The register offsets and register access over AXI4-Lite are this design's own decisions.
// Behaviour
// - Rate selector picks tick period 2^15..2^18
// - Selected tick clocks the watchdog stages
// - Reset sets both rate bits
// - Timeout seven and a half to eight tick periods
// - Divide-by-eight prescaler feeds 15-stage chain
// - Low eight stages readable, writes ignored
// - Chain cleared at power-on and delay end
// - Count step every eight oscillator cycles
// - Overflow event every 2048 oscillator cycles
// - Four watchdog stages, option enabled, reset MCU
// - Writing zero to clear bit restarts watchdog
// - Watchdog runs in run, wait, halt
// - Stop clears and gates the watchdog
// - Stop-to-halt option keeps watchdog on stop
// - Write-only code protect bit, sticky once set
// - Extra features bit drives one feature enable
// - Overflow flag sets on FF rollover, W1 clear
// - Tick flag sets on tick, W1 clear
`timescale 1ns/1ps
module ctw_core_timer
  import ctw_pkg::*;
#(
  parameter int STARTUP_LONG_CYCLES = CTW_DELAY_LONG_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic WDOG_ENABLE_OPTION,
  input wire logic STOP_TO_HALT_OPTION,
  input wire logic DELAY_LONG_OPTION,
  input wire logic STOP_REQ,
  input wire logic WAKE_REQ,
  output logic MCU_RESET_N,
  output logic CORE_OVF_IRQ,
  output logic TICK_IRQ,
  output logic CODE_PROTECT,
  output logic EXTRA_FEATURES,
  input wire logic [CTW_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [CTW_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ==========================================================================
  // Declarations
  ctw_state_t state_reg, state_next;
  logic [CTW_DELAY_BITS-1:0] delay_reg, delay_next;
  logic [CTW_PRESC_BITS-1:0] presc_reg, presc_next;
  logic [CTW_CHAIN_BITS-1:0] chain_reg, chain_next;
  logic [1:0] rate_reg, rate_next;
  logic ovf_en_reg, ovf_en_next;
  logic tick_en_reg, tick_en_next;
  logic ovf_flag_reg, ovf_flag_next;
  logic tick_flag_reg, tick_flag_next;
  logic protect_reg, protect_next;
  logic extra_reg, extra_next;
  logic stopped_reg, stopped_next;
  logic ovf_irq_reg, tick_irq_reg;
  logic mcu_rst_n_reg;
  logic [CTW_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic aw_have_reg, aw_have_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic w_have_reg, w_have_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic wr_fire;
  logic wd_clear;
  logic wd_enable;
  logic wd_timeout;
  logic step;
  logic tick_toggle;
  logic tick_event;
  logic ovf_event;
  logic in_startup;
  logic [CTW_DELAY_BITS-1:0] delay_limit;
  logic [3:0] tick_bit;

  assign in_startup = (state_reg == CTW_ST_STARTUP);
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  // ==========================================================================
  // Startup delay and MCU reset
  always_comb begin
    state_next = state_reg;
    delay_next = delay_reg;
    delay_limit = DELAY_LONG_OPTION ? CTW_DELAY_BITS'(STARTUP_LONG_CYCLES - 1)
                                    : CTW_DELAY_BITS'(CTW_DELAY_SHORT_CYC - 1);
    case (state_reg)
      CTW_ST_STARTUP: begin
        if (delay_reg >= delay_limit) begin
          state_next = CTW_ST_RUN;
          delay_next = '0;
        end else begin
          delay_next = delay_reg + 1'b1;
        end
      end
      CTW_ST_RUN: begin
        if (wd_timeout) begin
          state_next = CTW_ST_STARTUP;
          delay_next = '0;
        end
      end
      default: begin
        state_next = CTW_ST_STARTUP;
        delay_next = '0;
      end
    endcase
  end

  // ==========================================================================
  // Prescaler, counter chain and tick
  always_comb begin
    step = &presc_reg;
    presc_next = presc_reg + 1'b1;
    chain_next = step ? chain_reg + 1'b1 : chain_reg;
    if (in_startup && state_next == CTW_ST_RUN) begin
      presc_next = '0;
      chain_next = '0;
    end
    tick_bit = 4'(CTW_TICK_BASE_BIT) + {2'h0, rate_reg};
    tick_toggle = step && (chain_next[tick_bit] != chain_reg[tick_bit]);
    tick_event = tick_toggle && !chain_next[tick_bit];
    ovf_event = step && (&chain_reg[CTW_COUNT_BITS-1:0]);
  end

  // ==========================================================================
  // Control, flags and stop state
  always_comb begin
    rate_next = rate_reg;
    ovf_en_next = ovf_en_reg;
    tick_en_next = tick_en_reg;
    ovf_flag_next = ovf_flag_reg;
    tick_flag_next = tick_flag_reg;
    protect_next = protect_reg;
    extra_next = extra_reg;
    stopped_next = stopped_reg;
    wd_clear = 1'b0;
    if (wr_fire && wstrb_reg[0]) begin
      case (awaddr_reg)
        CTW_OFF_CTRL: begin
          rate_next = {wdata_reg[CTW_CT_RATE_HI_POS], wdata_reg[CTW_CT_RATE_LO_POS]};
          ovf_en_next = wdata_reg[CTW_CT_OVF_EN_POS];
          tick_en_next = wdata_reg[CTW_CT_TICK_EN_POS];
          if (wdata_reg[CTW_CT_OVF_CLR_POS]) begin
            ovf_flag_next = 1'b0;
          end
          if (wdata_reg[CTW_CT_TICK_CLR_POS]) begin
            tick_flag_next = 1'b0;
          end
        end
        CTW_OFF_WDSEC: begin
          wd_clear = !wdata_reg[CTW_WD_CLEAR_POS];
          extra_next = wdata_reg[CTW_WD_EXTRA_POS];
          protect_next = protect_reg | wdata_reg[CTW_WD_PROTECT_POS];
        end
        default: begin
          wd_clear = 1'b0;
        end
      endcase
    end
    if (ovf_event) begin
      ovf_flag_next = 1'b1;
    end
    if (tick_event) begin
      tick_flag_next = 1'b1;
    end
    if (STOP_REQ && !STOP_TO_HALT_OPTION) begin
      stopped_next = 1'b1;
    end else if (WAKE_REQ) begin
      stopped_next = 1'b0;
    end
    if (in_startup) begin
      rate_next = CTW_RATE_RESET;
      ovf_en_next = 1'b0;
      tick_en_next = 1'b0;
      ovf_flag_next = 1'b0;
      tick_flag_next = 1'b0;
      stopped_next = 1'b0;
      extra_next = 1'b0;
    end
  end

  assign wd_enable = WDOG_ENABLE_OPTION && !in_startup && !stopped_reg;

  // tick drives watchdog, sixteen half periods
  ctw_watchdog #(
    .STAGES(CTW_WD_STAGES)
  ) u_watchdog (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .ce(CE),
    .enable(wd_enable),
    .clr(wd_clear),
    .adv(tick_toggle),
    .timeout(wd_timeout)
  );

  // ==========================================================================
  // AXI4-Lite slave
  always_comb begin
    awaddr_next = awaddr_reg;
    aw_have_next = aw_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (S_AXI_AWVALID && !aw_have_reg) begin
      awaddr_next = {S_AXI_AWADDR[CTW_ADDR_W-1:2], 2'h0};
      aw_have_next = 1'b1;
    end
    if (S_AXI_WVALID && !w_have_reg) begin
      wdata_next = S_AXI_WDATA;
      wstrb_next = S_AXI_WSTRB;
      w_have_next = 1'b1;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == CTW_OFF_COUNT || awaddr_reg == CTW_OFF_WDSEC ||
                    awaddr_reg == CTW_OFF_CTRL) ? CTW_RESP_OKAY : CTW_RESP_SLVERR;
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end else if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = CTW_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case ({S_AXI_ARADDR[CTW_ADDR_W-1:2], 2'h0})
        CTW_OFF_COUNT: rdata_next[CTW_COUNT_BITS-1:0] = chain_reg[CTW_COUNT_BITS-1:0];
        CTW_OFF_WDSEC: rdata_next[CTW_WD_EXTRA_POS] = extra_reg;
        CTW_OFF_CTRL: begin
          rdata_next[CTW_CT_OVF_FLAG_POS] = ovf_flag_reg;
          rdata_next[CTW_CT_TICK_FLAG_POS] = tick_flag_reg;
          rdata_next[CTW_CT_OVF_EN_POS] = ovf_en_reg;
          rdata_next[CTW_CT_TICK_EN_POS] = tick_en_reg;
          rdata_next[CTW_CT_RATE_HI_POS] = rate_reg[1];
          rdata_next[CTW_CT_RATE_LO_POS] = rate_reg[0];
        end
        default: rresp_next = CTW_RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      state_reg <= CTW_ST_STARTUP;
      delay_reg <= '0;
      presc_reg <= '0;
      chain_reg <= '0;
      rate_reg <= CTW_RATE_RESET;
      ovf_en_reg <= 1'b0;
      tick_en_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      tick_flag_reg <= 1'b0;
      protect_reg <= 1'b0;
      extra_reg <= 1'b0;
      stopped_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
      tick_irq_reg <= 1'b0;
      mcu_rst_n_reg <= 1'b0;
      awaddr_reg <= '0;
      aw_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CTW_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= CTW_RESP_OKAY;
    end else if (CE) begin
      state_reg <= state_next;
      delay_reg <= delay_next;
      presc_reg <= presc_next;
      chain_reg <= chain_next;
      rate_reg <= rate_next;
      ovf_en_reg <= ovf_en_next;
      tick_en_reg <= tick_en_next;
      ovf_flag_reg <= ovf_flag_next;
      tick_flag_reg <= tick_flag_next;
      protect_reg <= protect_next;
      extra_reg <= extra_next;
      stopped_reg <= stopped_next;
      ovf_irq_reg <= ovf_flag_next && ovf_en_next;
      tick_irq_reg <= tick_flag_next && tick_en_next;
      mcu_rst_n_reg <= (state_next == CTW_ST_RUN);
      awaddr_reg <= awaddr_next;
      aw_have_reg <= aw_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign MCU_RESET_N = mcu_rst_n_reg;
  assign CORE_OVF_IRQ = ovf_irq_reg;
  assign TICK_IRQ = tick_irq_reg;
  assign CODE_PROTECT = protect_reg;
  assign EXTRA_FEATURES = extra_reg;
  assign S_AXI_AWREADY = !aw_have_reg;
  assign S_AXI_WREADY = !w_have_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
endmodule

// file: core/ctw_pkg.sv
/*
  Constants shared by the core timer and watchdog: register offsets, field
  positions, reset values and timing counts.
  Assumes a 32-bit AXI4-Lite register bus and the oscillator as SYS_CLK.
*/
package ctw_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] CTW_OFF_COUNT = 8'h00;
  localparam logic [7:0] CTW_OFF_WDSEC = 8'h04;
  localparam logic [7:0] CTW_OFF_CTRL = 8'h08;
  localparam int CTW_ADDR_W = 8;
  // ==========================================================================
  // Watchdog and security register fields
  localparam int CTW_WD_CLEAR_POS = 0;
  localparam int CTW_WD_EXTRA_POS = 1;
  localparam int CTW_WD_PROTECT_POS = 7;
  // ==========================================================================
  // Timer control register fields
  localparam int CTW_CT_RATE_LO_POS = 0;
  localparam int CTW_CT_RATE_HI_POS = 1;
  localparam int CTW_CT_TICK_CLR_POS = 2;
  localparam int CTW_CT_OVF_CLR_POS = 3;
  localparam int CTW_CT_TICK_EN_POS = 4;
  localparam int CTW_CT_OVF_EN_POS = 5;
  localparam int CTW_CT_TICK_FLAG_POS = 6;
  localparam int CTW_CT_OVF_FLAG_POS = 7;
  localparam logic [1:0] CTW_RATE_RESET = 2'h3;
  // ==========================================================================
  // Timer structure
  localparam int CTW_PRESC_BITS = 3;
  localparam int CTW_CHAIN_BITS = 15;
  localparam int CTW_COUNT_BITS = 8;
  localparam int CTW_WD_STAGES = 4;
  // Chain bit k has a period of 2^(k+4) oscillator cycles
  localparam int CTW_TICK_BASE_BIT = 11;
  // ==========================================================================
  // Startup delay, in bus cycles and in oscillator cycles
  localparam int CTW_OSC_PER_BUS = 2;
  localparam int CTW_DELAY_SHORT_BUS = 16;
  localparam int CTW_DELAY_LONG_BUS = 4064;
  localparam int CTW_DELAY_SHORT_CYC = CTW_DELAY_SHORT_BUS * CTW_OSC_PER_BUS;
  localparam int CTW_DELAY_LONG_CYC = CTW_DELAY_LONG_BUS * CTW_OSC_PER_BUS;
  localparam int CTW_DELAY_BITS = 16;
  // ==========================================================================
  // AXI responses
  localparam logic [1:0] CTW_RESP_OKAY = 2'h0;
  localparam logic [1:0] CTW_RESP_SLVERR = 2'h2;

  typedef enum logic {CTW_ST_STARTUP, CTW_ST_RUN} ctw_state_t;
endpackage

// file: core/ctw_watchdog.sv
/*
  Watchdog stages: a small binary counter advanced by each transition of the
  selected tick stage; a pulse leaves when all stages roll over.
  Assumes ADV and CLR come from logic on the same clock.
*/
`timescale 1ns/1ps
module ctw_watchdog #(
  parameter int STAGES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic clr,
  input wire logic adv,
  output logic timeout
);
  logic [STAGES-1:0] count_reg;
  logic [STAGES-1:0] count_next;
  logic timeout_reg;
  logic timeout_next;

  always_comb begin
    count_next = count_reg;
    timeout_next = 1'b0;
    if (clr || !enable) begin
      count_next = '0;
    end else if (adv) begin
      count_next = count_reg + 1'b1;
      timeout_next = &count_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
      timeout_reg <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      timeout_reg <= timeout_next;
    end
  end

  assign timeout = timeout_reg;
endmodule

// file: bench/ctw_core_timer_props.sv
/*
  Port checker for ctw_core_timer: bus handshakes, reset values, startup
  length, sticky protection and watchdog quiet when disabled.
  Assumes ctw_pkg is compiled first; bound to every ctw_core_timer.
*/
`timescale 1ns/1ps
module ctw_core_timer_props
  import ctw_pkg::*;
#(
  parameter int STARTUP_LONG_CYCLES = CTW_DELAY_LONG_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WDOG_ENABLE_OPTION,
  input wire logic DELAY_LONG_OPTION,
  input wire logic MCU_RESET_N,
  input wire logic CORE_OVF_IRQ,
  input wire logic TICK_IRQ,
  input wire logic CODE_PROTECT,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY
);
  import ctw_pkg::*;
  // ==========================================================================
  // Cycles spent in the startup delay
  int low_cnt_reg;
  int low_cnt_next;
  int dly_cyc;
  always_comb begin
    low_cnt_next = MCU_RESET_N ? 0 : low_cnt_reg + 1;
  end
  always_ff @(posedge SYS_CLK) begin
    low_cnt_reg <= RESETN ? low_cnt_next : 0;
  end
  assign dly_cyc = DELAY_LONG_OPTION ? STARTUP_LONG_CYCLES : CTW_DELAY_SHORT_CYC;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h000000) else $error("read answer late or wide");
  a_read_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("address ready while read pending");
  a_read_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response repeated");
  a_write_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_reset_values: assert property ($rose(RESETN) |-> !MCU_RESET_N && !CODE_PROTECT
    && !CORE_OVF_IRQ && !TICK_IRQ) else $error("outputs not cleared by reset");
  a_startup_len: assert property ($rose(MCU_RESET_N) |->
    low_cnt_reg >= dly_cyc - 2 && low_cnt_reg <= dly_cyc + 2) else $error("startup length wrong");
  a_protect_sticky: assert property (CODE_PROTECT |=> CODE_PROTECT)
    else $error("protection bit fell");
  a_wd_disabled: assert property (!WDOG_ENABLE_OPTION && MCU_RESET_N |=> MCU_RESET_N)
    else $error("reset while watchdog disabled");
  a_irq_held_off: assert property (!MCU_RESET_N ##1 !MCU_RESET_N |->
    !CORE_OVF_IRQ && !TICK_IRQ) else $error("interrupt during startup");
endmodule

bind ctw_core_timer ctw_core_timer_props #(.STARTUP_LONG_CYCLES(STARTUP_LONG_CYCLES))
  ctw_core_timer_props_inst (.SYS_CLK, .RESETN, .WDOG_ENABLE_OPTION, .DELAY_LONG_OPTION,
  .MCU_RESET_N, .CORE_OVF_IRQ, .TICK_IRQ, .CODE_PROTECT, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_BVALID, .S_AXI_BREADY);

// file: bench/ctw_core_timer_tb_top.sv
/*
  Self-checking bench for ctw_core_timer through AXI4-Lite accesses.
  Assumes ctw_pkg and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module ctw_core_timer_tb_top;
  import ctw_pkg::*;
  localparam int LONG_CYC = 64;
  logic clk, rst_n, stop_req, wake_req, wd_en, long_dly;
  logic mcu_rst_n, ovf_irq, tick_irq, protect, extra;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, k;
  logic [31:0] wdata, rdata, d, d2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, t_rd, n;

  ctw_core_timer #(.STARTUP_LONG_CYCLES(LONG_CYC)) ctw_core_timer_inst (
    .SYS_CLK(clk), .RESETN(rst_n), .CE(1'b1), .WDOG_ENABLE_OPTION(wd_en),
    .STOP_TO_HALT_OPTION(1'b0), .DELAY_LONG_OPTION(long_dly), .STOP_REQ(stop_req),
    .WAKE_REQ(wake_req), .MCU_RESET_N(mcu_rst_n), .CORE_OVF_IRQ(ovf_irq),
    .TICK_IRQ(tick_irq), .CODE_PROTECT(protect), .EXTRA_FEATURES(extra),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    t_rd = cyc;
    check(rresp, er);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {stop_req, wake_req, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {wd_en, long_dly} = 2'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    while (!mcu_rst_n) @(posedge clk);
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d, 32'h03);
    rd(CTW_OFF_WDSEC, d, CTW_RESP_OKAY);
    check(d, 32'h00);
    rd(8'h0C, d, CTW_RESP_SLVERR);
    check(d, 32'h00);
    wr(8'h10, 32'h01, CTW_RESP_SLVERR);
    // Count keeps pace across an ignored write
    rd(CTW_OFF_COUNT, d, CTW_RESP_OKAY);
    t0 = t_rd;
    wr(CTW_OFF_COUNT, 32'hFF, CTW_RESP_OKAY);
    rd(CTW_OFF_COUNT, d2, CTW_RESP_OKAY);
    k = d2[7:0] - d[7:0] - 8'((t_rd - t0) / 8);
    check(k <= 8'h01, 1'b1);
    // Overflow flag, enable, clear and period
    wr(CTW_OFF_CTRL, 32'h23, CTW_RESP_OKAY);
    while (!ovf_irq) @(posedge clk);
    t0 = cyc;
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d, 32'hA3);
    wr(CTW_OFF_CTRL, 32'h2B, CTW_RESP_OKAY);
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d, 32'h23);
    check(ovf_irq, 1'b0);
    while (!ovf_irq) @(posedge clk);
    check(cyc - t0, 2048);
    wr(CTW_OFF_CTRL, 32'h0B, CTW_RESP_OKAY);
    repeat (2100) @(posedge clk);
    check(ovf_irq, 1'b0);
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d, 32'h83);
    // Fastest tick rate, watchdog cleared first
    wr(CTW_OFF_WDSEC, 32'h00, CTW_RESP_OKAY);
    wr(CTW_OFF_CTRL, 32'h18, CTW_RESP_OKAY);
    while (!tick_irq) @(posedge clk);
    t0 = cyc;
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d & 32'h7F, 32'h50);
    wr(CTW_OFF_CTRL, 32'h14, CTW_RESP_OKAY);
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d & 32'h7F, 32'h10);
    check(tick_irq, 1'b0);
    while (!tick_irq) @(posedge clk);
    check(cyc - t0, 32768);
    // Protection and extra features
    wr(CTW_OFF_WDSEC, 32'h82, CTW_RESP_OKAY);
    rd(CTW_OFF_WDSEC, d, CTW_RESP_OKAY);
    check(d, 32'h02);
    check(protect, 1'b1);
    check(extra, 1'b1);
    wr(CTW_OFF_WDSEC, 32'h00, CTW_RESP_OKAY);
    rd(CTW_OFF_WDSEC, d, CTW_RESP_OKAY);
    check(protect, 1'b1);
    check(extra, 1'b0);
    // Stop and wake with the watchdog on, cleared first
    wd_en <= 1'b1;
    wr(CTW_OFF_WDSEC, 32'h00, CTW_RESP_OKAY);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (8) @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    repeat (8) @(posedge clk);
    check(mcu_rst_n, 1'b1);
    // Second reset with the long delay clears protection
    long_dly <= 1'b1;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (!mcu_rst_n) begin
      @(posedge clk);
      n++;
    end
    check(n, LONG_CYC + 1);
    check(protect, 1'b0);
    rd(CTW_OFF_CTRL, d, CTW_RESP_OKAY);
    check(d, 32'h03);
    give_verdict();
  end
endmodule
